// >>> rtl/ssr_pkg.sv
`default_nettype none

package ssr_pkg;

  // register bus geometry
  localparam int          ADDR_W = 16;
  localparam int          DATA_W = 8;

  // parameter identifiers used as register offsets
  localparam logic [15:0] OFS_ERROR_CODE    = 16'h1A03;
  localparam logic [15:0] OFS_IO_STATE_WORD = 16'h1A05;
  localparam logic [15:0] OFS_FIRST_INPUT   = 16'h1A50;
  localparam logic [15:0] OFS_SECOND_INPUT  = 16'h1A51;
  localparam logic [15:0] OFS_SAFE_OUTPUT   = 16'h1A52;
  localparam logic [15:0] OFS_ACK_INPUT     = 16'h1A53;

  // io state word field positions
  localparam int          IO_FIRST_INPUT_BIT  = 0;
  localparam int          IO_SECOND_INPUT_BIT = 1;
  localparam int          IO_SAFE_OUTPUT_BIT  = 2;
  localparam int          IO_ACK_INPUT_BIT    = 3;

  // reset values
  localparam logic [7:0]  RST_ERROR_CODE = 8'h00;
  localparam logic [7:0]  RST_IO_STATE   = 8'h00;
  localparam logic [7:0]  RST_RDATA      = 8'h00;

  // error codes, in order of priority (lowest code wins)
  localparam int          NUM_FAULTS        = 12;
  localparam logic [7:0]  ERR_NONE          = 8'h00;
  localparam logic [7:0]  ERR_VALIDATION    = 8'h0E;
  localparam logic [7:0]  ERR_AUTH          = 8'h0F;
  localparam logic [7:0]  ERR_SAFE_ADDRESS  = 8'h10;
  localparam logic [7:0]  ERR_FIELDBUS_CFG  = 8'h11;
  localparam logic [7:0]  ERR_BRAKE_OUTPUT  = 8'h12;
  localparam logic [7:0]  ERR_TEMPERATURE   = 8'h13;
  localparam logic [7:0]  ERR_TIMING        = 8'h14;
  localparam logic [7:0]  ERR_DISCREPANCY   = 8'h15;
  localparam logic [7:0]  ERR_INTERNAL      = 8'h16;
  localparam logic [7:0]  ERR_IO            = 8'h17;
  localparam logic [7:0]  ERR_TASK_CALC     = 8'h18;
  localparam logic [7:0]  ERR_TASK_PERIOD   = 8'h19;

  // misc values
  localparam logic [7:0]  FORBIDDEN_SAFE_ADDRESS = 8'hFF;
  localparam logic [7:0]  ERR_STATE_IO_FAILURE   = 8'h01;

endpackage

`default_nettype wire

// >>> rtl/ssr_status.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_status (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_resetn,
  // register port
  input  wire logic [ssr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ssr_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [ssr_pkg::DATA_W-1:0] o_rdata,
  // safety io connector pins, asynchronous
  input  wire logic                       i_in1_ch_a,
  input  wire logic                       i_in1_ch_b,
  input  wire logic                       i_in2_ch_a,
  input  wire logic                       i_in2_ch_b,
  input  wire logic                       i_safe_out,
  input  wire logic                       i_ack_in,
  // fault reports from the safety task logic
  input  wire logic                       i_validation_fail,
  input  wire logic                       i_auth_fail,
  input  wire logic [7:0]                 i_safe_address,
  input  wire logic                       i_fieldbus_cfg_err,
  input  wire logic                       i_brake_fault,
  input  wire logic                       i_over_temp,
  input  wire logic                       i_timing_fault,
  input  wire logic                       i_channel_mismatch,
  input  wire logic                       i_internal_fault,
  input  wire logic                       i_io_fault,
  input  wire logic                       i_task_calc_overrun,
  input  wire logic                       i_task_period_high,
  // error acknowledge and error state
  input  wire logic                       i_error_ack,
  input  wire logic [7:0]                 i_error_state,
  // safe reactions
  output logic                            o_sto_active,
  output logic                            o_brake_engage,
  output logic      [7:0]                 o_error_code
);
  import ssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [7:0] err_code;
    logic [7:0] io_state;
    logic [7:0] rdata;
    logic       sto;
    logic       brake;
  } ssr_state_s;

  ssr_state_s state_ff;
  ssr_state_s nxt_state;

  // synchronised pin levels, order matches the sync vector
  logic                  in1_a_s;
  logic                  in1_b_s;
  logic                  in2_a_s;
  logic                  in2_b_s;
  logic                  out_s;
  logic                  ack_s;
  logic [NUM_FAULTS-1:0] fault_evt;
  logic                  any_fault;
  logic [7:0]            new_code;

  assign in1_a_s = state_ff.sync2[0];
  assign in1_b_s = state_ff.sync2[1];
  assign in2_a_s = state_ff.sync2[2];
  assign in2_b_s = state_ff.sync2[3];
  assign out_s   = state_ff.sync2[4];
  assign ack_s   = state_ff.sync2[5];

  ////////////////////////////////////////////////////////////////////////////
  // fault collection

  // bit k stands for code ERR_VALIDATION + k
  always_comb begin
    fault_evt[0]  = i_validation_fail;
    fault_evt[1]  = i_auth_fail;
    fault_evt[2]  = (i_safe_address == FORBIDDEN_SAFE_ADDRESS);
    fault_evt[3]  = i_fieldbus_cfg_err;
    fault_evt[4]  = i_brake_fault;
    fault_evt[5]  = i_over_temp;
    fault_evt[6]  = i_timing_fault;
    fault_evt[7]  = i_channel_mismatch;
    fault_evt[8]  = i_internal_fault;
    fault_evt[9]  = i_io_fault;
    fault_evt[10] = i_task_calc_overrun;
    fault_evt[11] = i_task_period_high;
  end

  // any report at all, address fault included
  assign any_fault = |fault_evt;

  // lowest code wins so that one report per cycle is deterministic
  // limitation: a lower-priority fault in the same cycle is not recorded
  always_comb begin
    new_code = ERR_NONE;
    for (int k = NUM_FAULTS - 1; k >= 0; k--) begin
      if (fault_evt[k]) begin
        new_code = ERR_VALIDATION + 8'(k);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_state = state_ff;

    // two-stage synchroniser for connector pins
    // only the second stage is read; the first may be metastable
    nxt_state.sync1 = {i_ack_in, i_safe_out, i_in2_ch_b, i_in2_ch_a, i_in1_ch_b, i_in1_ch_a};
    nxt_state.sync2 = state_ff.sync1;

    // io state word, upper nibble held at zero
    nxt_state.io_state                      = RST_IO_STATE;
    nxt_state.io_state[IO_FIRST_INPUT_BIT]  = in1_a_s & in1_b_s;
    nxt_state.io_state[IO_SECOND_INPUT_BIT] = in2_a_s & in2_b_s;
    nxt_state.io_state[IO_SAFE_OUTPUT_BIT]  = out_s;
    nxt_state.io_state[IO_ACK_INPUT_BIT]    = ack_s;

    // a new fault beats an acknowledge in the same cycle
    if (any_fault) begin
      nxt_state.err_code = new_code;
    end else if (i_error_ack) begin
      nxt_state.err_code = ERR_NONE;
    end

    // safe reactions follow the error state
    nxt_state.sto   = (i_error_state == ERR_STATE_IO_FAILURE);
    nxt_state.brake = (i_error_state == ERR_STATE_IO_FAILURE);

    // read data stands for one cycle only; writes are ignored
    nxt_state.rdata = RST_RDATA;
    if (i_rd) begin
      case (i_addr)
        OFS_ERROR_CODE:    nxt_state.rdata = state_ff.err_code;
        OFS_IO_STATE_WORD: nxt_state.rdata = state_ff.io_state;
        OFS_FIRST_INPUT:   nxt_state.rdata = {7'h00, state_ff.io_state[IO_FIRST_INPUT_BIT]};
        OFS_SECOND_INPUT:  nxt_state.rdata = {7'h00, state_ff.io_state[IO_SECOND_INPUT_BIT]};
        OFS_SAFE_OUTPUT:   nxt_state.rdata = {7'h00, state_ff.io_state[IO_SAFE_OUTPUT_BIT]};
        OFS_ACK_INPUT:     nxt_state.rdata = {7'h00, state_ff.io_state[IO_ACK_INPUT_BIT]};
        default:           nxt_state.rdata = RST_RDATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // reset drives safe reactions off; error state takes over next cycle
  // io word and read data are cleared too, so nothing stale leaks out
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff          <= '0;
      state_ff.err_code <= RST_ERROR_CODE;
      state_ff.io_state <= RST_IO_STATE;
      state_ff.rdata    <= RST_RDATA;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata        = state_ff.rdata;
  assign o_sto_active   = state_ff.sto;
  assign o_brake_engage = state_ff.brake;
  assign o_error_code   = state_ff.err_code;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // every check below is suspended while reset is held
  default clocking ast_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // write data is deliberately unused: every entry is read-only
  logic unused_wr;
  assign unused_wr = i_wr ^ (|i_wdata);

  AST_VALIDATION: assert property (fault_evt[0] |=> o_error_code == ERR_VALIDATION)
    else $error("validation fault code wrong");
  AST_AUTH: assert property (fault_evt[1] && !fault_evt[0] |=> o_error_code == ERR_AUTH)
    else $error("authentication fault code wrong");
  AST_SAFE_ADDR: assert property (fault_evt[2] && fault_evt[1:0] == 2'h0
    |=> o_error_code == ERR_SAFE_ADDRESS)
    else $error("safe address fault code wrong");
  AST_FIELDBUS: assert property (fault_evt[3] && fault_evt[2:0] == 3'h0
    |=> o_error_code == ERR_FIELDBUS_CFG)
    else $error("fieldbus config fault code wrong");
  AST_BRAKE: assert property (fault_evt[4] && fault_evt[3:0] == 4'h0
    |=> o_error_code == ERR_BRAKE_OUTPUT)
    else $error("brake fault code wrong");
  AST_TEMP: assert property (fault_evt[5] && fault_evt[4:0] == 5'h00
    |=> o_error_code == ERR_TEMPERATURE)
    else $error("temperature fault code wrong");
  AST_TIMING: assert property (fault_evt[6] && fault_evt[5:0] == 6'h00
    |=> o_error_code == ERR_TIMING)
    else $error("timing fault code wrong");
  AST_DISCREP: assert property (fault_evt[7] && fault_evt[6:0] == 7'h00
    |=> o_error_code == ERR_DISCREPANCY)
    else $error("discrepancy fault code wrong");
  AST_INTERNAL: assert property (fault_evt[8] && fault_evt[7:0] == 8'h00
    |=> o_error_code == ERR_INTERNAL)
    else $error("internal fault code wrong");
  AST_IO: assert property (fault_evt[9] && fault_evt[8:0] == 9'h000
    |=> o_error_code == ERR_IO)
    else $error("io fault code wrong");
  AST_CALC: assert property (fault_evt[10] && fault_evt[9:0] == 10'h000
    |=> o_error_code == ERR_TASK_CALC)
    else $error("task calc fault code wrong");
  AST_PERIOD: assert property (fault_evt[11] && fault_evt[10:0] == 11'h000
    |=> o_error_code == ERR_TASK_PERIOD)
    else $error("task period fault code wrong");

  // pin level travels three flops into the io word; reset edges do not count
  sequence s_in1_both;
    i_resetn && i_in1_ch_a && i_in1_ch_b;
  endsequence
  sequence s_in2_both;
    i_resetn && i_in2_ch_a && i_in2_ch_b;
  endsequence

  AST_IN1: assert property (s_in1_both ##1 s_in1_both ##1 s_in1_both
    |=> state_ff.io_state[IO_FIRST_INPUT_BIT])
    else $error("first input bit not set");
  AST_IN1_CLR: assert property (!i_in1_ch_a [*3] |=> !state_ff.io_state[IO_FIRST_INPUT_BIT])
    else $error("first input bit not cleared");
  AST_IN2: assert property (s_in2_both ##1 s_in2_both ##1 s_in2_both
    |=> state_ff.io_state[IO_SECOND_INPUT_BIT])
    else $error("second input bit not set");
  AST_OUT: assert property (out_s |=> state_ff.io_state[IO_SAFE_OUTPUT_BIT])
    else $error("safe output bit wrong");
  AST_ACK: assert property ((i_resetn && i_ack_in) [*3]
    |=> state_ff.io_state[IO_ACK_INPUT_BIT])
    else $error("acknowledge bit not set");
  AST_MIRROR: assert property (i_rd && i_addr == OFS_SAFE_OUTPUT
    |=> o_rdata == {7'h00, $past(state_ff.io_state[IO_SAFE_OUTPUT_BIT])})
    else $error("mirror read wrong");
  AST_MIRROR_IN1: assert property (i_rd && i_addr == OFS_FIRST_INPUT
    |=> o_rdata[0] == $past(state_ff.io_state[IO_FIRST_INPUT_BIT]) && o_rdata[7:1] == 7'h00)
    else $error("first input mirror read wrong");
  AST_STO: assert property (i_error_state == ERR_STATE_IO_FAILURE
    |=> o_sto_active && o_brake_engage)
    else $error("safe reaction missing in io failure");
  AST_RSVD: assert property (state_ff.io_state[7:4] == 4'h0)
    else $error("reserved io bits not zero");
  AST_HOLD: assert property (!any_fault && !i_error_ack |=> $stable(o_error_code))
    else $error("error code changed without cause");
  AST_CLEAR: assert property (!any_fault && i_error_ack |=> o_error_code == ERR_NONE)
    else $error("acknowledge did not clear code");

  // clear side of the pin bits: one low channel drops the bit
  AST_IN1_CLR_B: assert property (!i_in1_ch_b [*3]
    |=> !state_ff.io_state[IO_FIRST_INPUT_BIT])
    else $error("first input bit not cleared by channel b");
  AST_IN2_CLR: assert property (!i_in2_ch_a [*3]
    |=> !state_ff.io_state[IO_SECOND_INPUT_BIT])
    else $error("second input bit not cleared");
  AST_IN2_CLR_B: assert property (!i_in2_ch_b [*3]
    |=> !state_ff.io_state[IO_SECOND_INPUT_BIT])
    else $error("second input bit not cleared by channel b");
  AST_OUT_CLR: assert property (!out_s |=> !state_ff.io_state[IO_SAFE_OUTPUT_BIT])
    else $error("safe output bit not cleared");
  AST_ACK_CLR: assert property (!i_ack_in [*3]
    |=> !state_ff.io_state[IO_ACK_INPUT_BIT])
    else $error("acknowledge bit not cleared");

  // register reads answer one cycle later with the value seen at the strobe
  sequence s_rd_code;
    i_rd && i_addr == OFS_ERROR_CODE;
  endsequence
  sequence s_rd_word;
    i_rd && i_addr == OFS_IO_STATE_WORD;
  endsequence
  sequence s_rd_mirror;
    i_rd && i_addr >= OFS_FIRST_INPUT && i_addr <= OFS_ACK_INPUT;
  endsequence

  AST_READ_CODE: assert property (s_rd_code |=> o_rdata == $past(o_error_code))
    else $error("error code read wrong");
  AST_READ_WORD: assert property (s_rd_word |=> o_rdata == $past(state_ff.io_state))
    else $error("io word read wrong");
  AST_MIRROR_HIGH: assert property (s_rd_mirror |=> o_rdata[7:1] == 7'h00)
    else $error("mirror read upper bits not zero");
  AST_MIRROR_IN2: assert property (i_rd && i_addr == OFS_SECOND_INPUT
    |=> o_rdata == {7'h00, $past(state_ff.io_state[IO_SECOND_INPUT_BIT])})
    else $error("second input mirror read wrong");
  AST_MIRROR_ACK: assert property (i_rd && i_addr == OFS_ACK_INPUT
    |=> o_rdata == {7'h00, $past(state_ff.io_state[IO_ACK_INPUT_BIT])})
    else $error("acknowledge mirror read wrong");
  // read data must fall back so a stale value is never taken as an answer
  AST_READ_IDLE: assert property (!i_rd |=> o_rdata == RST_RDATA)
    else $error("read data outside a read");

  // error code register and safe reactions
  AST_ACK_LOST: assert property (any_fault && i_error_ack |=> o_error_code != ERR_NONE)
    else $error("acknowledge beat a new fault");
  AST_CODE_RANGE: assert property (o_error_code == ERR_NONE
    || (o_error_code >= ERR_VALIDATION && o_error_code <= ERR_TASK_PERIOD))
    else $error("error code outside the reported set");
  AST_STO_OFF: assert property (i_error_state != ERR_STATE_IO_FAILURE
    |=> !o_sto_active && !o_brake_engage)
    else $error("safe reaction outside io failure");
  AST_STO_PAIR: assert property (o_sto_active == o_brake_engage)
    else $error("torque off and brake disagree");
  // forbidden address is a level fault, so an acknowledge cannot clear it
  AST_ADDR_KEEP: assert property (fault_evt[2] && fault_evt[1:0] == 2'h0 && i_error_ack
    |=> o_error_code == ERR_SAFE_ADDRESS)
    else $error("forbidden address cleared by acknowledge");
  // writes have no effect on the error code entry
  AST_WR_IGNORED: assert property (i_wr && !any_fault && !i_error_ack
    |=> o_error_code == $past(o_error_code))
    else $error("write changed the error code");

endmodule

`default_nettype wire

// >>> verif/tb_safety_status_reporting.sv
`timescale 1ns/1ps
`default_nettype none

module tb_safety_status_reporting;
  import ssr_pkg::*;

  // run ceiling, far above the roughly 1100 cycles needed
  localparam int LIMIT = 20000;

  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [5:0]        pins;    // in1 a, in1 b, in2 a, in2 b, safe out, ack in
  logic [11:0]       flt;     // fault reports in code order, bit 2 unused
  logic [7:0]        saddr;
  logic              eack;
  logic [7:0]        estate;
  logic              sto;
  logic              brake;
  logic [7:0]        ecode;
  logic [7:0]        d;
  logic [7:0]        exp_io;
  int                err_count   = 0;
  int                comparisons = 0;
  int                cycles      = 0;

  ssr_status dut (
    .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_in1_ch_a(pins[0]), .i_in1_ch_b(pins[1]),
    .i_in2_ch_a(pins[2]), .i_in2_ch_b(pins[3]), .i_safe_out(pins[4]),
    .i_ack_in(pins[5]), .i_validation_fail(flt[0]), .i_auth_fail(flt[1]),
    .i_safe_address(saddr), .i_fieldbus_cfg_err(flt[3]), .i_brake_fault(flt[4]),
    .i_over_temp(flt[5]), .i_timing_fault(flt[6]), .i_channel_mismatch(flt[7]),
    .i_internal_fault(flt[8]), .i_io_fault(flt[9]), .i_task_calc_overrun(flt[10]),
    .i_task_period_high(flt[11]), .i_error_ack(eack), .i_error_state(estate),
    .o_sto_active(sto), .o_brake_engage(brake), .o_error_code(ecode)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data valid only in the cycle after the strobe, sampled 1 ns past that edge
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic ack_pulse();
    @(posedge clk);
    eack <= 1'b1;
    @(posedge clk);
    eack <= 1'b0;
    #1;
  endtask

  // one-cycle report of fault i; safe address stands in for index 2
  task automatic fault_pulse(input int i);
    @(posedge clk);
    if (i == 2) saddr <= 8'hFF;
    else flt[i] <= 1'b1;
    @(posedge clk);
    flt   <= '0;
    saddr <= 8'h00;
    #1 chk("error code", 8'h0E + 8'(i), ecode);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk("error code", 8'h00, ecode);
    chk("sto", 8'h00, {7'h00, sto});
    chk("brake", 8'h00, {7'h00, brake});
    bus_rd(OFS_ERROR_CODE, d);
    chk("error code read", 8'h00, d);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 12; i++) begin
      fault_pulse(i);
      repeat (3) @(posedge clk);
      bus_rd(OFS_ERROR_CODE, d);
      chk("held code", 8'h0E + 8'(i), d);
      ack_pulse();
      chk("acked code", 8'h00, ecode);
    end
  endtask

  // forbidden address stays a fault while present, so ack must not clear it
  task automatic t_addr_level();
    @(posedge clk);
    saddr <= 8'hFF;
    repeat (3) @(posedge clk);
    ack_pulse();
    @(posedge clk);
    saddr <= 8'h00;
    #1 chk("address fault", 8'h10, ecode);
    ack_pulse();
    ack_pulse();
    chk("address cleared", 8'h00, ecode);
  endtask

  // every pin combination through the word and the four mirrors
  task automatic t_io();
    for (int p = 0; p < 64; p++) begin
      @(posedge clk);
      pins <= 6'(p);
      repeat (4) @(posedge clk);
      exp_io = {4'h0, pins[5], pins[4], pins[2] & pins[3], pins[0] & pins[1]};
      bus_rd(OFS_IO_STATE_WORD, d);
      chk("io word", exp_io, d);
      for (int k = 0; k < 4; k++) begin
        bus_rd(OFS_FIRST_INPUT + 16'(k), d);
        chk("io mirror", {7'h00, exp_io[k]}, d);
      end
    end
  endtask

  // writes are ignored, unmapped reads give zero, data stand one cycle only
  task automatic t_bus_edges();
    bus_wr(OFS_ERROR_CODE, 8'hA5);
    bus_rd(OFS_ERROR_CODE, d);
    chk("written code", 8'h00, d);
    @(posedge clk);
    pins <= 6'h3F;
    repeat (4) @(posedge clk);
    bus_rd(16'h1A04, d);
    chk("unmapped", 8'h00, d);
    bus_rd(OFS_IO_STATE_WORD, d);
    chk("io word", 8'h0F, d);
    @(posedge clk);
    #1 chk("idle read data", 8'h00, rdata);
  endtask

  task automatic t_estate();
    @(posedge clk);
    estate <= ERR_STATE_IO_FAILURE;
    @(posedge clk);
    @(posedge clk);
    estate <= 8'h02;
    #1 chk("sto", 8'h01, {7'h00, sto});
    chk("brake", 8'h01, {7'h00, brake});
    @(posedge clk);
    @(posedge clk);
    #1 chk("sto off", 8'h00, {7'h00, sto});
    chk("brake off", 8'h00, {7'h00, brake});
  endtask

  // mid-run reset drops a held code; pins stay high across the release
  task automatic t_mid_reset();
    fault_pulse(5);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("reset code", 8'h00, ecode);
    chk("reset sto", 8'h00, {7'h00, sto});
    repeat (4) @(posedge clk);
    bus_rd(OFS_IO_STATE_WORD, d);
    chk("io word after reset", 8'h0F, d);
    bus_rd(OFS_ERROR_CODE, d);
    chk("code read after reset", 8'h00, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn <= 1'b0;
    addr   <= '0;
    wdata  <= '0;
    wr     <= 1'b0;
    rd     <= 1'b0;
    pins   <= '0;
    flt    <= '0;
    saddr  <= 8'h00;
    eack   <= 1'b0;
    estate <= 8'h00;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 t_reset();
    t_codes();
    t_addr_level();
    t_io();
    t_bus_edges();
    t_estate();
    t_mid_reset();
    wrap_up();
  end

endmodule

`default_nettype wire
